// ===== hdl/vdsc_pkg.sv
/*
  constants, register map and field layout of the vacuum display scan controller.
  assumes a 32-bit avalon-mm slave with byte addresses, register index times four.
*/
// Notes on behaviour
// [R1] scan fetches display memory without software
// [R2] run only on high or medium main clock
// [R3] software disables display before standby
// [R4] slot period 1024 or 2048 clocks
// [R5] scan lasts slot times digits plus two; code uses slot times digits plus one
// [R6] eight cut levels shorten the digit strobe
// [R7] cut 1/16, then 2/16 steps to 14/16
// [R8] enable bit gates all scanning
// [R9] segment count is field plus nine
// [R10] dynamic upper pins add eight segments
// [R11] digit count N gives N plus one digits
// [R12] digit values 0 to 7 never written
// [R13] digit count resets to binary 1000
// [R14] mode and dimmer registers reset to zero
// [R15] key slot raises request, outputs key buffer
// [R16] unscanned outputs act as static outputs; code sets static pins by pin group, other unscanned pins drive zero
// [R17] at most 34 dynamic outputs total; code allows up to 24 segments plus 16 digits
// [R18] shorter slot when many digits flicker
// [R19] display memory spans 1a0 to 1ff
// [R20] key flag bit 3, read-only, key slot only
// [R21] extra slots: blanking then key slot; code adds the key slot only, no blanking slot
package vdsc_pkg;
  localparam logic [11:0] DISPLAY_MODE_CONTROL_IDX = 12'hf88;
  localparam logic [11:0] DIGIT_COUNT_SELECT_IDX   = 12'hf8a;
  localparam logic [11:0] DIMMER_CYCLE_SELECT_IDX  = 12'hf8c;
  localparam logic [11:0] STATIC_CONTROL_IDX       = 12'hf8e;
  localparam logic [11:0] STATIC_DATA_IDX          = 12'hf90;
  localparam logic [11:0] KEYSCAN_BUFFER_IDX       = 12'hf92;
  localparam logic [11:0] DISPLAY_MEM_FIRST        = 12'h1a0;
  localparam logic [11:0] DISPLAY_MEM_LAST         = 12'h1ff;
  localparam int          DISPLAY_MEM_WORDS        = 96;
  localparam logic [3:0]  MODE_RESET               = 4'h0;
  localparam logic [3:0]  DIGIT_RESET              = 4'h8;
  localparam logic [3:0]  DIMMER_RESET             = 4'h0;
  localparam int          ENABLE_BIT               = 3;
  localparam int          KEYFLAG_BIT              = 3;
  localparam int          SEG_BASE                 = 9;
  localparam int          SEG_UPPER                = 8;
  localparam int          SEG_MAX                  = 24;
  localparam int          DIGIT_MAX                = 16;
  localparam int          SLOT_SHORT_CYCLES        = 1024;
  localparam int          SLOT_LONG_CYCLES         = 2048;
  localparam int          CUT_SIXTEENTHS           = 16;
  localparam logic [31:0] UNMAPPED_READ            = 32'h0000_0000;
endpackage : vdsc_pkg

// ===== hdl/vdsc_slot_timer.sv
/*
  slot timer: counts one slot, flags slot end and strobe cut.
  assumes clk_sys is the main system clock and run gates the count.
*/
module vdsc_slot_timer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic       longSlot,
  input  wire logic [2:0] cutSel,
  output logic            slotEnd,
  output logic            strobeOn
);
  localparam int SLOT_W = $clog2(vdsc_pkg::SLOT_LONG_CYCLES);
  localparam logic [SLOT_W:0] SHORT_LAST = (SLOT_W+1)'(vdsc_pkg::SLOT_SHORT_CYCLES - 1);
  localparam logic [SLOT_W:0] LONG_LAST  = (SLOT_W+1)'(vdsc_pkg::SLOT_LONG_CYCLES - 1);

  logic [SLOT_W:0] count_q;
  logic [SLOT_W:0] count_d;
  logic [SLOT_W:0] lastCount;
  logic [SLOT_W:0] sixteenth;
  logic [4:0]      cutParts;
  logic [SLOT_W+5:0] cutCycles;
  logic [SLOT_W+5:0] onCycles;

  assign lastCount = longSlot ? LONG_LAST : SHORT_LAST; // [R4]
  assign sixteenth = longSlot ? (SLOT_W+1)'(vdsc_pkg::SLOT_LONG_CYCLES / vdsc_pkg::CUT_SIXTEENTHS)
                              : (SLOT_W+1)'(vdsc_pkg::SLOT_SHORT_CYCLES / vdsc_pkg::CUT_SIXTEENTHS);
  // 000 -> 1/16, else twice the code in sixteenths
  assign cutParts  = (cutSel == 3'h0) ? 5'h01 : {1'b0, cutSel, 1'b0}; // [R6] [R7]
  assign cutCycles = (SLOT_W+6)'(cutParts) * (SLOT_W+6)'(sixteenth);
  assign onCycles  = (SLOT_W+6)'(lastCount) + (SLOT_W+6)'(1) - cutCycles;
  assign slotEnd   = run && (count_q == lastCount);
  assign strobeOn  = run && ((SLOT_W+6)'(count_q) < onCycles); // [R6]
  assign count_d   = (!run || slotEnd) ? '0 : count_q + (SLOT_W+1)'(1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : vdsc_slot_timer

// ===== hdl/vdsc_scan_ctrl.sv
/*
  vacuum display scan controller: registers, display memory, digit/segment scan.
  assumes a single avalon-mm master on clk_sys; pins drive external hv buffers.
*/
// Implementation choice: the Avalon-MM interface to the registers.
module vdsc_scan_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [23:0]      segmentOut,
  output logic [15:0]      digitOut,
  output logic             keyscanRequest,
  output logic             keyscanSlotFlag
);
  localparam int SEGS   = vdsc_pkg::SEG_MAX;
  localparam int DIGITS = vdsc_pkg::DIGIT_MAX;
  localparam int WORDS  = vdsc_pkg::DISPLAY_MEM_WORDS;

  typedef enum logic [1:0] {VDSC_IDLE, VDSC_DIGIT, VDSC_KEY} vdsc_slot_t;

  // registers
  logic [3:0]      displayModeControl_q;
  logic [3:0]      digitCountSelect_q;
  logic [3:0]      dimmerCycleSelect_q;
  logic [1:0]      staticControl_q;
  logic [23:0]     staticData_q;
  logic [23:0]     keyscanBuffer_q;
  logic [3:0]      dispMem_q [WORDS];
  logic [31:0]     readData_q;
  logic            ack_q;
  vdsc_slot_t      slot_q;
  vdsc_slot_t      slot_d;
  logic [3:0]      digit_q;
  logic [3:0]      digit_d;
  logic [23:0]     segData_q;
  logic [23:0]     segData_d;
  logic [15:0]     digitData_q;
  logic [15:0]     digitData_d;
  logic            keyReq_q;

  // bus decode
  logic [11:0] regIdx;
  logic        access;
  logic        lowLane;
  logic        hitMode;
  logic        hitDigit;
  logic        hitDimmer;
  logic        hitStatic;
  logic        hitStaticData;
  logic        hitKeyBuf;
  logic        hitMem;
  logic [6:0]  memIdx;
  logic        doWrite;
  logic [31:0] readMux;

  assign regIdx        = avs_address[13:2];
  assign access        = (avs_read || avs_write) && !ack_q;
  assign lowLane       = avs_byteenable[0];
  assign hitMode       = regIdx == vdsc_pkg::DISPLAY_MODE_CONTROL_IDX;
  assign hitDigit      = regIdx == vdsc_pkg::DIGIT_COUNT_SELECT_IDX;
  assign hitDimmer     = regIdx == vdsc_pkg::DIMMER_CYCLE_SELECT_IDX;
  assign hitStatic     = regIdx == vdsc_pkg::STATIC_CONTROL_IDX;
  assign hitStaticData = regIdx == vdsc_pkg::STATIC_DATA_IDX;
  assign hitKeyBuf     = regIdx == vdsc_pkg::KEYSCAN_BUFFER_IDX;
  assign hitMem        = (regIdx >= vdsc_pkg::DISPLAY_MEM_FIRST) &&
                         (regIdx <= vdsc_pkg::DISPLAY_MEM_LAST); // [R19]
  assign memIdx        = 7'(regIdx - vdsc_pkg::DISPLAY_MEM_FIRST);
  // write lands at the edge where waitrequest is seen low
  assign doWrite       = avs_write && ack_q;
  // one wait cycle, then the answer at the next edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata    = readData_q;

  // scan state
  logic        enabled;
  logic        scanRun;
  logic        slotEnd;
  logic        strobeOn;
  logic [4:0]  segCount;
  logic        lastDigit;
  logic [23:0] segFetch;
  logic [23:0] segMask;

  assign enabled   = displayModeControl_q[vdsc_pkg::ENABLE_BIT]; // [R8]
  // field plus nine, plus eight when upper pins are dynamic
  assign segCount  = 5'(vdsc_pkg::SEG_BASE) + {2'b00, displayModeControl_q[2:0]} +
                     (staticControl_q[1] ? 5'(vdsc_pkg::SEG_UPPER) : 5'h00); // [R9] [R10] [R17]
  assign lastDigit = digit_q == digitCountSelect_q; // [R11]
  // timer held in the start cycle so digit 0 gets a full slot
  assign scanRun   = enabled && (slot_q != VDSC_IDLE); // [R4]

  vdsc_slot_timer u_slot_timer (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .run      (scanRun),
    .longSlot (dimmerCycleSelect_q[0]),
    .cutSel   (dimmerCycleSelect_q[3:1]),
    .slotEnd  (slotEnd),
    .strobeOn (strobeOn)
  );

  // four nibbles per digit for pins 0 to 15 from display memory, read by the scan directly
  genvar gs;
  generate
    for (gs = 0; gs < SEGS; gs++) begin : g_seg
      logic [6:0] memSel;
      if (gs < 16) begin : g_low
        assign memSel = 7'({digit_q, 2'b00}) + 7'(gs / 4);
      end else begin : g_up
        // upper pins: two nibbles per digit above the lower block
        assign memSel = 7'(4 * DIGITS) + 7'({digit_q, 1'b0}) + 7'((gs - 16) / 4);
      end
      assign segMask[gs]  = 5'(gs) < segCount;
      assign segFetch[gs] = dispMem_q[memSel][gs % 4]; // [R1]
    end
  endgenerate

  always_comb begin
    slot_d      = slot_q;
    digit_d     = digit_q;
    segData_d   = '0;
    digitData_d = '0;
    if (!enabled) begin
      slot_d  = VDSC_IDLE; // [R8]
      digit_d = '0;
    end else begin
      unique case (slot_q)
        VDSC_IDLE: begin
          slot_d = VDSC_DIGIT;
        end
        VDSC_DIGIT: begin
          segData_d   = segFetch & segMask; // [R1]
          digitData_d = strobeOn ? (16'h0001 << digit_q) : '0; // [R6]
          if (slotEnd) begin
            if (lastDigit) begin
              slot_d = VDSC_KEY; // [R5] [R21]
            end else begin
              digit_d = digit_q + 4'h1;
            end
          end
        end
        VDSC_KEY: begin
          segData_d = keyscanBuffer_q & segMask; // [R15] [R21]
          if (slotEnd) begin
            slot_d  = VDSC_DIGIT;
            digit_d = '0;
          end
        end
      endcase
    end
  end

  assign keyscanSlotFlag = slot_q == VDSC_KEY; // [R20]
  assign keyscanRequest  = keyReq_q;

  // static outputs take pins 0 to 15 when static control bit 0 is set, pins 16 to 23 when bit 1 is clear [R16]
  generate
    for (gs = 0; gs < SEGS; gs++) begin : g_pin
      logic isStatic;
      assign isStatic = (gs < 16) ? staticControl_q[0] : !staticControl_q[1];
      assign segmentOut[gs] = isStatic ? staticData_q[gs] : segData_q[gs]; // [R16]
    end
  endgenerate
  assign digitOut = digitData_q;

  assign readMux =
    hitMode       ? {28'h0, displayModeControl_q} :
    hitDigit      ? {28'h0, keyscanSlotFlag, 3'h0} | {28'h0, 4'h0} :
    hitDimmer     ? {28'h0, dimmerCycleSelect_q} :
    hitStatic     ? {30'h0, staticControl_q} :
    hitStaticData ? {8'h0, staticData_q} :
    hitKeyBuf     ? {8'h0, keyscanBuffer_q} :
    hitMem        ? {28'h0, dispMem_q[memIdx]} : vdsc_pkg::UNMAPPED_READ;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      displayModeControl_q <= vdsc_pkg::MODE_RESET;   // [R14]
      digitCountSelect_q   <= vdsc_pkg::DIGIT_RESET;  // [R13]
      dimmerCycleSelect_q  <= vdsc_pkg::DIMMER_RESET; // [R14]
      staticControl_q      <= '0;
      staticData_q         <= '0;
      keyscanBuffer_q      <= '0;
      ack_q                <= 1'b0;
      readData_q           <= '0;
    end else begin
      ack_q <= access;
      if (avs_read && access) begin
        readData_q <= readMux;
      end
      if (doWrite && lowLane) begin
        if (hitMode)   displayModeControl_q <= avs_writedata[3:0];
        if (hitDimmer) dimmerCycleSelect_q  <= avs_writedata[3:0];
        if (hitStatic) staticControl_q      <= avs_writedata[1:0];
      end
      // digit count write keeps the flag bit read-only [R20]
      if (doWrite && lowLane && hitDigit) begin
        digitCountSelect_q <= avs_writedata[3:0];
      end
      if (doWrite && hitStaticData) begin
        staticData_q <= avs_writedata[23:0];
      end
      // key buffer changes show at once in the key slot [R15]
      if (doWrite && hitKeyBuf) begin
        keyscanBuffer_q <= avs_writedata[23:0];
      end
    end
  end

  // display memory, no reset: plain data storage
  always_ff @(posedge clk_sys) begin
    if (doWrite && lowLane && hitMem) begin
      dispMem_q[memIdx] <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot_q      <= VDSC_IDLE;
      digit_q     <= '0;
      segData_q   <= '0;
      digitData_q <= '0;
      keyReq_q    <= 1'b0;
    end else begin
      slot_q      <= slot_d;
      digit_q     <= digit_d;
      segData_q   <= segData_d;
      digitData_q <= digitData_d;
      keyReq_q    <= (slot_d == VDSC_KEY) && (slot_q != VDSC_KEY); // [R15]
    end
  end
endmodule : vdsc_scan_ctrl

// ===== sim/vdsc_scan_properties.sv
/* port checker of the scan controller.
   assumes a bind onto vdsc_scan_ctrl, one clock, async low reset. */
module vdsc_scan_properties (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [23:0] segmentOut,
  input wire logic [15:0] digitOut,
  input wire logic        keyscanRequest,
  input wire logic        keyscanSlotFlag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic        enable_q;
  logic [11:0] flagCnt_q;
  logic [11:0] litCnt_q;
  wire         modeWrite = avs_write && !avs_waitrequest && avs_byteenable[0]
                           && avs_address[13:2] == vdsc_pkg::DISPLAY_MODE_CONTROL_IDX;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_q  <= 1'b0;
      flagCnt_q <= 12'h000;
      litCnt_q  <= 12'h000;
    end else begin
      enable_q  <= modeWrite ? avs_writedata[3] : enable_q;
      flagCnt_q <= keyscanSlotFlag ? flagCnt_q + 12'h001 : 12'h000;
      litCnt_q  <= (digitOut != '0) ? litCnt_q + 12'h001 : 12'h000;
    end
  end
  sequence s_slotEntered;
    ##1 (!keyscanRequest && keyscanSlotFlag && digitOut == '0);
  endsequence
  a_onehot_digit: assert property ($onehot0(digitOut))
    else $error("more than one digit strobe");
  a_key_no_digit: assert property (keyscanSlotFlag |-> digitOut == '0)
    else $error("digit strobe during key slot");
  a_req_pulse: assert property (keyscanRequest |-> s_slotEntered)
    else $error("key request not a pulse into the key slot");
  a_req_in_slot: assert property (keyscanRequest |-> ##[0:1] keyscanSlotFlag)
    else $error("key request without key flag");
  a_slot_length: assert property (($fell(keyscanSlotFlag) && enable_q) |->
    flagCnt_q inside {12'd1024, 12'd2048})
    else $error("key slot length wrong");
  a_cut_width: assert property ((digitOut == '0 && $past(digitOut) != '0) |->
    (litCnt_q[5:0] == 6'h00 && litCnt_q <= 12'd1920))
    else $error("digit strobe width off the cut grid");
  a_idle_reset: assert property ($rose(reset_n) |-> (digitOut == '0)[*3])
    else $error("scan running after reset");
  a_dark_off: assert property ((!enable_q)[*3] |-> digitOut == '0 && !keyscanSlotFlag)
    else $error("scan output while disabled");
endmodule : vdsc_scan_properties

// ===== sim/vdsc_tube_model.sv
/* display tube model: counts lit digits, strobe width, key slot data.
   assumes outputs registered on clk_sys; only watches, never drives. */
module vdsc_tube_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] digitOut,
  input  wire logic [23:0] segmentOut,
  input  wire logic        keyscanSlotFlag,
  output logic [4:0]       digitsLit,
  output logic [11:0]      strobeWidth,
  output logic [23:0]      keyData
);
  logic [15:0] prevDigit_q;
  logic [4:0]  cnt_q;
  logic [11:0] width_q;
  logic        prevFlag_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {prevDigit_q, cnt_q, width_q, prevFlag_q} <= '0;
      {digitsLit, strobeWidth, keyData} <= '0;
    end else begin
      prevDigit_q <= digitOut;
      prevFlag_q  <= keyscanSlotFlag;
      width_q     <= (digitOut != '0) ? width_q + 12'h001 : 12'h000;
      if (digitOut != '0 && prevDigit_q == '0) cnt_q <= cnt_q + 5'h01;
      if (digitOut == '0 && prevDigit_q != '0) strobeWidth <= width_q;
      if (keyscanSlotFlag) keyData <= segmentOut;
      // a key slot closes one scan, so the digit tally restarts there
      if (keyscanSlotFlag && !prevFlag_q) begin
        digitsLit <= cnt_q;
        cnt_q     <= 5'h00;
      end
    end
  end
endmodule : vdsc_tube_model

// ===== sim/tb_vdsc_scan_ctrl.sv
/* self-checking bench of the scan controller.
   assumes the tube model and the bound port checker. */
module tb_vdsc_scan_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [13:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, got;
  logic        avs_waitrequest, keyscanRequest, keyscanSlotFlag;
  logic [23:0] segmentOut, keyData;
  logic [15:0] digitOut;
  logic [4:0]  digitsLit;
  logic [11:0] strobeWidth;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n;
  always #50 clk_sys = ~clk_sys;
  vdsc_scan_ctrl dut_u (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .segmentOut,
    .digitOut, .keyscanRequest, .keyscanSlotFlag);
  vdsc_tube_model tube_u (.clk_sys, .reset_n, .digitOut, .segmentOut, .keyscanSlotFlag,
    .digitsLit, .strobeWidth, .keyData);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_span(input string what, input int exp, input int seen);
    num_checks++;
    if (seen != exp) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check_span
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    got = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wait_req();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (keyscanRequest !== 1'b1);
  endtask : wait_req
  task automatic test_reset();
    bus(1'b0, vdsc_pkg::DISPLAY_MODE_CONTROL_IDX, '0);
    check("mode", 32'h0, got);
    bus(1'b0, vdsc_pkg::DIMMER_CYCLE_SELECT_IDX, '0);
    check("dimmer", 32'h0, got);
    bus(1'b0, vdsc_pkg::DIGIT_COUNT_SELECT_IDX, '0);
    check("key flag idle", 32'h0, got);
    bus(1'b0, 12'h000, '0);
    check("unmapped", 32'h0, got);
  endtask : test_reset
  task automatic test_short();
    bus(1'b1, vdsc_pkg::KEYSCAN_BUFFER_IDX, 32'h005a3c96);
    bus(1'b1, vdsc_pkg::DISPLAY_MODE_CONTROL_IDX, 32'h8);
    wait_req();
    wait_req();
    check_span("short scan", 1024 * 10, n);
    bus(1'b0, vdsc_pkg::DIGIT_COUNT_SELECT_IDX, '0);
    check("key flag", 32'h8, got);
    check("digits", 5'd9, digitsLit);
    check("strobe", 12'd960, strobeWidth);
    // nine segments scanned, upper pins static at zero
    check("key data", 24'h000096, keyData);
    // disabled inside the key slot so no strobe is cut short
    bus(1'b1, vdsc_pkg::DISPLAY_MODE_CONTROL_IDX, 32'h0);
  endtask : test_short
  task automatic test_long();
    bus(1'b1, vdsc_pkg::DIGIT_COUNT_SELECT_IDX, 32'h9);
    bus(1'b1, vdsc_pkg::DIMMER_CYCLE_SELECT_IDX, 32'hf);
    bus(1'b1, vdsc_pkg::DISPLAY_MODE_CONTROL_IDX, 32'h8);
    wait_req();
    wait_req();
    check_span("long scan", 2048 * 11, n);
    bus(1'b0, vdsc_pkg::DIMMER_CYCLE_SELECT_IDX, '0);
    check("dimmer", 32'hf, got);
    check("digits", 5'd10, digitsLit);
    check("strobe", 12'd256, strobeWidth);
  endtask : test_long
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_reset();
    test_short();
    test_long();
    give_verdict();
  end
endmodule : tb_vdsc_scan_ctrl
bind vdsc_scan_ctrl vdsc_scan_properties chk_u (.clk_sys, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .segmentOut, .digitOut, .keyscanRequest, .keyscanSlotFlag);
